/* rtl/pack_protect_status_regs.sv */
// Purpose: Status registers of the pack protection front end behind a two-wire slave
// Assumes: Host clock pin sampled by i_clk_sys; control bits come from same-clock logic
// Notes: Register pointer auto-increments on reads; register writes are acked, ignored
// Operation
// - Bit 7 config shows upper cascade, fixed
// - Bit 6 config shows lower cascade, fixed
// - Wake status bit driven by hardware only
// - Wake bit follows pin, polarity selects inversion
// - External overtemp sticky, cleared by read after
// - Internal overtemp sticky, cleared by read after
// - Load fail sets on discharge short or discharge overcurrent with heavy load
// - Load fail clears on read once light
// - Discharge short sticky, read clears when gone
// - Discharge overcurrent sticky, read clears when gone
// - Charge overcurrent sticky, read clears when gone
// - Fault flags clear on read; others track
// - Upper device reads lower-only bits as zero
// - Load fail detection only while monitor enabled
`timescale 1ns/10ps
module pack_protect_status_regs import pack_protect_pkg::*; #(
   parameter bit IS_UPPER = 1'b0,
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   input wire logic i_wake_pin_above,
   input wire logic i_wake_polarity_select,
   input wire logic i_load_monitor_enable,
   input wire logic i_load_heavy,
   input wire logic i_external_overtemp,
   input wire logic i_internal_overtemp,
   input wire logic i_discharge_short,
   input wire logic i_discharge_overcurrent,
   input wire logic i_charge_overcurrent,
   output logic [7:0] o_config_status,
   output logic [7:0] o_operating_fault_status
);
   typedef struct packed {
      link_state_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [1:0] byte_idx;
      logic rw;
      logic [7:0] ptr;
      logic scl_prev;
      logic sda_prev;
      logic sda_oe;
      logic sda_out;
      logic [7:0] cfg;
      logic [7:0] flags;
   } status_state_t;

   status_state_t s_reg;
   status_state_t s_next;
   logic [SYNC_W-1:0] sy;
   logic rd_clr;
   logic do_load;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic [7:0] cond;
   logic [7:0] hold;
   logic [7:0] valid;
   logic [7:0] rd_byte;

   signal_sync u_sync (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_async({i_scl, i_sda, i_wake_pin_above, i_external_overtemp, i_internal_overtemp,
                i_load_heavy, i_discharge_short, i_discharge_overcurrent,
                i_charge_overcurrent}),
      .o_sync(sy)
   );

   function automatic logic [7:0] read_byte(input logic [7:0] ptr, input logic [7:0] cfg,
                                            input logic [7:0] flags);
      case (ptr)
         REG_CONFIG_STATUS: read_byte = cfg;
         REG_OPERATING_FAULT_STATUS: read_byte = flags;
         default: read_byte = READ_UNMAPPED;
      endcase
   endfunction

   always_comb begin
      s_next = s_reg;
      rd_clr = 1'b0;
      do_load = 1'b0;
      scl_rise = sy[IN_SCL] & ~s_reg.scl_prev;
      scl_fall = ~sy[IN_SCL] & s_reg.scl_prev;
      start_seen = sy[IN_SCL] & s_reg.scl_prev & s_reg.sda_prev & ~sy[IN_SDA];
      stop_seen = sy[IN_SCL] & s_reg.scl_prev & ~s_reg.sda_prev & sy[IN_SDA];
      rd_byte = read_byte(s_reg.ptr, s_reg.cfg, s_reg.flags);
      s_next.scl_prev = sy[IN_SCL];
      s_next.sda_prev = sy[IN_SDA];
      s_next.sda_out = 1'b0;
      if (start_seen) begin
         s_next.st = ST_RECV;
         s_next.cnt = 4'h0;
         s_next.byte_idx = BYTE_ADDR;
         s_next.sda_oe = 1'b0;
      end else if (stop_seen) begin
         s_next.st = ST_IDLE;
         s_next.sda_oe = 1'b0;
      end else begin
         case (s_reg.st)
            ST_RECV: begin
               if (scl_rise) begin
                  s_next.sh = {s_reg.sh[6:0], sy[IN_SDA]};
                  s_next.cnt = s_reg.cnt + 4'h1;
               end else if (scl_fall && s_reg.cnt == BITS_PER_BYTE) begin
                  if (s_reg.byte_idx == BYTE_ADDR && s_reg.sh[7:1] != DEV_ADDR) begin
                     s_next.st = ST_IDLE;
                  end else begin
                     s_next.st = ST_ACK;
                     s_next.sda_oe = 1'b1;
                     if (s_reg.byte_idx == BYTE_ADDR) begin
                        s_next.rw = s_reg.sh[0];
                     end
                     if (s_reg.byte_idx == BYTE_PTR) begin
                        s_next.ptr = s_reg.sh;
                     end
                     if (s_reg.byte_idx != BYTE_DATA) begin
                        s_next.byte_idx = s_reg.byte_idx + 2'h1;
                     end
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  s_next.sda_oe = 1'b0;
                  s_next.cnt = 4'h0;
                  if (s_reg.rw && s_reg.byte_idx == BYTE_PTR) begin
                     do_load = 1'b1;
                  end else begin
                     // Status is read-only: written data is acked and dropped
                     s_next.st = ST_RECV;
                  end
               end
            end
            ST_SEND: begin
               if (scl_fall) begin
                  if (s_reg.cnt == BITS_PER_BYTE) begin
                     s_next.sda_oe = 1'b0;
                     s_next.st = ST_MACK;
                  end else begin
                     s_next.sh = {s_reg.sh[6:0], 1'b0};
                     s_next.sda_oe = ~s_reg.sh[6];
                     s_next.cnt = s_reg.cnt + 4'h1;
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise && sy[IN_SDA]) begin
                  s_next.st = ST_IDLE;
               end else if (scl_fall) begin
                  do_load = 1'b1;
               end
            end
            default: begin
               s_next.st = ST_IDLE;
               s_next.sda_oe = 1'b0;
            end
         endcase
      end
      if (do_load) begin
         // Clear happens on the byte load, so data shown is the pre-clear value
         rd_clr = (s_reg.ptr == REG_OPERATING_FAULT_STATUS);
         s_next.sh = rd_byte;
         s_next.sda_oe = ~rd_byte[7];
         s_next.cnt = 4'h1;
         s_next.ptr = s_reg.ptr + 8'h01;
         s_next.st = ST_SEND;
      end
      // Only the wake bit can move; cascade bits are constants
      s_next.cfg = {IS_UPPER, ~IS_UPPER, 1'b0, 1'b0, 4'h0};
      s_next.cfg[CFG_WAKE_BIT] = ~(sy[IN_WAKE] ^ i_wake_polarity_select);
      cond = 8'h00;
      cond[OP_XOT_BIT] = sy[IN_XOT];
      cond[OP_IOT_BIT] = sy[IN_IOT];
      cond[OP_LDF_BIT] = i_load_monitor_enable & sy[IN_HEAVY] &
                         (sy[IN_DSC] | sy[IN_DOC]);
      cond[OP_DSC_BIT] = sy[IN_DSC];
      cond[OP_DOC_BIT] = sy[IN_DOC];
      cond[OP_COC_BIT] = sy[IN_COC];
      hold = cond;
      hold[OP_LDF_BIT] = i_load_monitor_enable & sy[IN_HEAVY];
      valid = IS_UPPER ? ~OP_LOWER_ONLY_MASK : 8'hff;
      // Set wins over the read clear, so no event is lost
      s_next.flags = (cond | (s_reg.flags & ~({8{rd_clr}} & ~hold))) & valid;
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg <= '0;
         s_reg.st <= ST_IDLE;
         s_reg.cfg <= {IS_UPPER, ~IS_UPPER, CFG_LOW_RESET};
         s_reg.flags <= OP_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_sda_out = s_reg.sda_out;
   assign o_sda_oe = s_reg.sda_oe;
   assign o_config_status = s_reg.cfg;
   assign o_operating_fault_status = s_reg.flags;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);

   property p_upper_flag;
      o_config_status[CFG_UPPER_BIT] == IS_UPPER;
   endproperty
   a_upper_flag: assert property (p_upper_flag) else $error("upper flag wrong");
   property p_lower_flag;
      o_config_status[CFG_LOWER_BIT] == !IS_UPPER;
   endproperty
   a_lower_flag: assert property (p_lower_flag) else $error("lower flag wrong");
   property p_wake_hw_only;
      $past(i_rst_n) && $stable(sy[IN_WAKE] ^ i_wake_polarity_select) |=>
         $stable(o_config_status[CFG_WAKE_BIT]);
   endproperty
   a_wake_hw_only: assert property (p_wake_hw_only) else $error("wake moved alone");
   property p_wake_polarity;
      $past(i_rst_n) |->
         o_config_status[CFG_WAKE_BIT] == ($past(sy[IN_WAKE]) ~^ $past(i_wake_polarity_select));
   endproperty
   a_wake_polarity: assert property (p_wake_polarity) else $error("wake polarity");
   property p_xot_set;
      sy[IN_XOT] && !IS_UPPER ##1 !sy[IN_XOT] && !rd_clr |=> o_operating_fault_status[OP_XOT_BIT];
   endproperty
   a_xot_set: assert property (p_xot_set) else $error("xot not sticky");
   property p_iot_set;
      sy[IN_IOT] ##1 !rd_clr [*2] |=> o_operating_fault_status[OP_IOT_BIT];
   endproperty
   a_iot_set: assert property (p_iot_set) else $error("iot not sticky");
   property p_ldf_set;
      !IS_UPPER && i_load_monitor_enable && sy[IN_HEAVY] && sy[IN_DOC]
         |=> o_operating_fault_status[OP_LDF_BIT];
   endproperty
   a_ldf_set: assert property (p_ldf_set) else $error("load fail not set");
   property p_ldf_clear;
      rd_clr && !sy[IN_HEAVY] |=> !o_operating_fault_status[OP_LDF_BIT];
   endproperty
   a_ldf_clear: assert property (p_ldf_clear) else $error("load fail kept");
   property p_dsc_clear;
      rd_clr && !sy[IN_DSC] |=> !o_operating_fault_status[OP_DSC_BIT];
   endproperty
   a_dsc_clear: assert property (p_dsc_clear) else $error("short kept");
   property p_doc_set;
      !IS_UPPER && sy[IN_DOC] |=> o_operating_fault_status[OP_DOC_BIT];
   endproperty
   a_doc_set: assert property (p_doc_set) else $error("doc not set");
   property p_coc_clear;
      rd_clr && !sy[IN_COC] |=> !o_operating_fault_status[OP_COC_BIT];
   endproperty
   a_coc_clear: assert property (p_coc_clear) else $error("coc kept");
   property p_no_read_keep;
      !rd_clr && o_operating_fault_status[OP_IOT_BIT] |=> o_operating_fault_status[OP_IOT_BIT];
   endproperty
   a_no_read_keep: assert property (p_no_read_keep) else $error("flag lost");
   property p_upper_zero;
      IS_UPPER |-> (o_operating_fault_status & OP_LOWER_ONLY_MASK) == 8'h00;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("lower bit in upper");
   property p_monitor_off;
      !i_load_monitor_enable && !o_operating_fault_status[OP_LDF_BIT]
         |=> !o_operating_fault_status[OP_LDF_BIT];
   endproperty
   a_monitor_off: assert property (p_monitor_off) else $error("load fail while off");
   property p_set_wins;
      rd_clr && sy[IN_IOT] |=> o_operating_fault_status[OP_IOT_BIT];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost on read");
endmodule

/* rtl/pack_protect_pkg.sv */
// Purpose: Shared constants and types for the pack protection status registers
// Assumes: Two-wire serial slave, byte-wide registers at 0x00 and 0x01
// Notes: Synchroniser bit order is fixed by the IN_* indices below
package pack_protect_pkg;
   localparam logic [7:0] REG_CONFIG_STATUS = 8'h00;
   localparam logic [7:0] REG_OPERATING_FAULT_STATUS = 8'h01;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam int CFG_UPPER_BIT = 7;
   localparam int CFG_LOWER_BIT = 6;
   localparam int CFG_VARIANT_BIT = 5;
   localparam int CFG_WAKE_BIT = 4;
   localparam int OP_XOT_BIT = 5;
   localparam int OP_IOT_BIT = 4;
   localparam int OP_LDF_BIT = 3;
   localparam int OP_DSC_BIT = 2;
   localparam int OP_DOC_BIT = 1;
   localparam int OP_COC_BIT = 0;
   localparam logic [7:0] OP_LOWER_ONLY_MASK = 8'h2f;
   localparam logic [7:0] OP_RESET = 8'h00;
   localparam logic [5:0] CFG_LOW_RESET = 6'h00;
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h50;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam int SYNC_W = 9;
   localparam int IN_SCL = 8;
   localparam int IN_SDA = 7;
   localparam int IN_WAKE = 6;
   localparam int IN_XOT = 5;
   localparam int IN_IOT = 4;
   localparam int IN_HEAVY = 3;
   localparam int IN_DSC = 2;
   localparam int IN_DOC = 1;
   localparam int IN_COC = 0;
   localparam logic [1:0] BYTE_ADDR = 2'h0;
   localparam logic [1:0] BYTE_PTR = 2'h1;
   localparam logic [1:0] BYTE_DATA = 2'h2;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RECV = 3'b001,
      ST_ACK = 3'b010,
      ST_SEND = 3'b011,
      ST_MACK = 3'b100
   } link_state_t;
endpackage

/* rtl/signal_sync.sv */
// Purpose: Two-flop synchroniser for all pin and detector inputs
// Assumes: Inputs are levels, slower than the system clock
// Notes: First stage is read only by the second stage
`timescale 1ns/10ps
module signal_sync import pack_protect_pkg::*; (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [SYNC_W-1:0] i_async,
   output logic [SYNC_W-1:0] o_sync
);
   typedef struct packed {
      logic [SYNC_W-1:0] meta_reg;
      logic [SYNC_W-1:0] sync_reg;
   } sync_state_t;
   sync_state_t s_reg;
   sync_state_t s_next;

   always_comb begin
      s_next.meta_reg = i_async;
      s_next.sync_reg = s_reg.meta_reg;
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_sync = s_reg.sync_reg;
endmodule

/* tb/twi_host_model.sv */
// Purpose: Host side of the two-wire bus, open drain, pull-up on data
// Assumes: Clock pin idles high and stands still between frames
// Notes: Low 7, high 7 system cycles per bit
`timescale 1ns/10ps
module twi_host_model (
   input wire logic i_clk_sys,
   input wire logic i_sda_line,
   output logic o_scl,
   output logic o_sda
);
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask
   // Data moves one cycle after the clock falls, never while it is high
   task automatic bit_io(input logic b, output logic seen);
      o_sda <= b;
      w(6);
      o_scl <= 1'b1;
      w(7);
      seen = i_sda_line;
      o_scl <= 1'b0;
      w(1);
   endtask
   task automatic tx(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(v[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   task automatic start();
      o_sda <= 1'b1;
      w(1);
      o_scl <= 1'b1;
      w(7);
      o_sda <= 1'b0;
      w(7);
      o_scl <= 1'b0;
      w(1);
   endtask
   task automatic access(input logic [6:0] dev, input logic [7:0] ptr, input logic wr,
                         input logic [7:0] wd, output logic [7:0] rd, output logic ok);
      logic a0, a1, a2, s;
      rd = 8'h00;
      start();
      tx({dev, 1'b0}, a0);
      tx(ptr, a1);
      if (wr) begin
         tx(wd, a2);
      end else begin
         start();
         tx({dev, 1'b1}, a2);
         for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, rd[i]);
         end
         bit_io(1'b1, s);
      end
      o_sda <= 1'b0;
      w(6);
      o_scl <= 1'b1;
      w(7);
      o_sda <= 1'b1;
      w(7);
      ok = a0 & a1 & a2;
   endtask
endmodule

/* tb/pack_protect_status_regs_tb.sv */
// Purpose: Self-checking bench, lower and upper device on one bus
// Assumes: Seeded xorshift stimulus, first passes fixed corners
// Notes: Config bit 5 masked out of compares
`timescale 1ns/10ps
module pack_protect_status_regs_tb import pack_protect_pkg::*;;
   logic clk, rst_n, scl, sda_m, pin, pol, en, hv;
   logic [4:0] f;
   logic oe0, oe1, sdo0, sdo1;
   logic [7:0] cfg0, cfg1, op0, op1, v;
   logic [31:0] seed;
   int fails, check_count;
   wire logic sda = sda_m & ~oe0 & ~oe1;
   pack_protect_status_regs i_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_scl(scl),
      .i_sda(sda), .o_sda_out(sdo0), .o_sda_oe(oe0), .i_wake_pin_above(pin),
      .i_wake_polarity_select(pol), .i_load_monitor_enable(en), .i_load_heavy(hv),
      .i_external_overtemp(f[4]), .i_internal_overtemp(f[3]), .i_discharge_short(f[2]),
      .i_discharge_overcurrent(f[1]), .i_charge_overcurrent(f[0]),
      .o_config_status(cfg0), .o_operating_fault_status(op0));
   pack_protect_status_regs #(.IS_UPPER(1'b1), .DEV_ADDR(7'h51)) i_dut_upper (
      .i_clk_sys(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda_out(sdo1),
      .o_sda_oe(oe1), .i_wake_pin_above(pin), .i_wake_polarity_select(pol),
      .i_load_monitor_enable(en), .i_load_heavy(hv), .i_external_overtemp(f[4]),
      .i_internal_overtemp(f[3]), .i_discharge_short(f[2]),
      .i_discharge_overcurrent(f[1]), .i_charge_overcurrent(f[0]),
      .o_config_status(cfg1), .o_operating_fault_status(op1));
   twi_host_model u_host (.i_clk_sys(clk), .i_sda_line(sda), .o_scl(scl), .o_sda(sda_m));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] ecfg(input int up, input logic p, input logic w);
      return {up[0], ~up[0], 1'b0, ~(p ^ w), 4'h0};
   endfunction
   // Upper device hides every lower-only flag
   function automatic logic [7:0] eop(input int up, input logic [4:0] c, input logic l);
      logic [7:0] e;
      e = {2'b00, c[4], c[3], l, c[2:0]};
      return (up == 1) ? (e & ~OP_LOWER_ONLY_MASK) : e;
   endfunction
   task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask
   task automatic rd(input int up, input logic [7:0] ptr, input logic wr, output logic [7:0] d);
      logic ok;
      u_host.access(up ? 7'h51 : DEV_ADDR_DEFAULT, ptr, wr, 8'hff, d, ok);
      check("ack", 8'h01, {7'h00, ok});
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      conclude();
   end
   initial begin
      logic [31:0] r;
      logic [4:0] kp;
      logic l, l2, h2;
      {rst_n, pin, pol, en, hv, f, seed} = {10'h000, 32'd86078};
      repeat (8) @(posedge clk);
      check("cfg0 reset", 8'h40, cfg0 & 8'hdf);
      check("cfg1 reset", 8'h80, cfg1 & 8'hdf);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      for (int k = 0; k < 4; k++) begin
         {pol, pin} <= k[1:0];
         repeat (6) @(posedge clk);
         for (int up = 0; up < 2; up++) begin
            rd(up, 8'h00, 1'b1, v);
            rd(up, REG_CONFIG_STATUS, 1'b0, v);
            check("cfg bus", ecfg(up, pol, pin), v & 8'hdf);
            check("cfg port", ecfg(up, pol, pin), (up ? cfg1 : cfg0) & 8'hdf);
         end
      end
      rd(0, 8'h09, 1'b0, v);
      check("unmapped", READ_UNMAPPED, v);
      check("sda out", 8'h00, {6'h00, sdo0, sdo1});
      for (int i = 0; i < 10; i++) begin
         r = (i == 0) ? 32'h0000ffff : rnd();
         kp = r[12:8];
         l = r[5] & r[6] & (r[2] | r[1]);
         h2 = r[5] & r[13];
         l2 = l & r[5] & h2;
         {en, hv, f} <= r[6:0];
         repeat (5) @(posedge clk);
         f <= r[4:0] & kp;
         hv <= h2;
         repeat (5) @(posedge clk);
         for (int up = 0; up < 2; up++) begin
            rd(up, REG_OPERATING_FAULT_STATUS, 1'b0, v);
            check("op first", eop(up, r[4:0], l), v);
            check("op port", eop(up, r[4:0] & kp, l2), up ? op1 : op0);
         end
         f <= 5'h00;
         hv <= 1'b0;
         repeat (5) @(posedge clk);
         for (int up = 0; up < 2; up++) begin
            rd(up, REG_OPERATING_FAULT_STATUS, 1'b0, v);
            check("op kept", eop(up, r[4:0] & kp, l2), v);
            rd(up, REG_OPERATING_FAULT_STATUS, 1'b0, v);
            check("op clear", 8'h00, v);
         end
      end
      conclude();
   end
endmodule
